//--- bsie_pkg.sv
// Package: register map, field layout and carrier types of the bridge/supply interrupt enables
package bsie_pkg;

   // ------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] BSIE_OFS_BRIDGE_EN = 8'h5C;
   localparam logic [7:0] BSIE_OFS_SUPPLY_EN = 8'h60;
   localparam logic [7:0] BSIE_OFS_BRIDGE_ST = 8'h64;
   localparam logic [7:0] BSIE_OFS_SUPPLY_ST = 8'h68;

   // ------------------------------------------------------------
   // Field layout and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] BSIE_BRIDGE_MASK  = 32'h001F_3C0F;
   localparam logic [31:0] BSIE_SUPPLY_MASK  = 32'h0000_00FF;
   localparam logic [31:0] BSIE_BRIDGE_RESET = 32'h0000_0000;
   localparam logic [31:0] BSIE_SUPPLY_RESET = 32'h0000_0000;

   localparam int BSIE_DRV_SUPPLY_HIGH = 20;
   localparam int BSIE_DRV_SUPPLY_LOW  = 19;
   localparam int BSIE_PUMP_HIGH       = 18;
   localparam int BSIE_PUMP_LOW_FIRST  = 17;
   localparam int BSIE_PUMP_LOW_SECOND = 16;
   localparam int BSIE_HIGH_B_OC       = 13;
   localparam int BSIE_HIGH_A_OC       = 12;
   localparam int BSIE_LOW_B_OC        = 11;
   localparam int BSIE_LOW_A_OC        = 10;
   localparam int BSIE_HIGH_B_SHORT    = 3;
   localparam int BSIE_HIGH_A_SHORT    = 2;
   localparam int BSIE_LOW_B_SHORT     = 1;
   localparam int BSIE_LOW_A_SHORT     = 0;
   localparam int BSIE_CORE_OVER       = 7;
   localparam int BSIE_FIVE_OVER       = 6;
   localparam int BSIE_MAIN_OVER       = 5;
   localparam int BSIE_BATT_OVER       = 4;
   localparam int BSIE_CORE_UNDER      = 3;
   localparam int BSIE_FIVE_UNDER      = 2;
   localparam int BSIE_MAIN_UNDER      = 1;
   localparam int BSIE_BATT_UNDER      = 0;

   // ------------------------------------------------------------
   // Carrier types
   // ------------------------------------------------------------
   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } bsie_apb_req_t;

   typedef struct packed {
      logic [31:0] bridge;
      logic [31:0] supply;
   } bsie_irq_vec_t;

endpackage

//--- bsie_edge.sv
// Rising-edge catcher for the supply monitor conditions
module bsie_edge (
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   input  wire logic [7:0] level_in,
   output logic      [7:0] rise_out
);
   logic [7:0] prev_q;

   // ------------------------------------------------------------
   // Previous level, per bit
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_bit
         always_ff @(posedge clk_in) begin
            if (!nrst_in) begin
               prev_q[gi] <= 1'b0;
            end else begin
               prev_q[gi] <= level_in[gi];
            end
         end
         // Edge only, so a stuck fault raises one event, not a storm
         assign rise_out[gi] = level_in[gi] & ~prev_q[gi];
      end
   endgenerate
endmodule

//--- bsie_top.sv
// Bridge and supply interrupt enable block with APB register slave
module bsie_top (
   input  wire logic        clk_in,
   input  wire logic        nrst_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [7:0]  paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic      [31:0] prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   input  wire logic [31:0] bridge_event_in,
   input  wire logic [7:0]  supply_level_in,
   output logic      [31:0] bridge_req_out,
   output logic      [7:0]  supply_req_out,
   output logic             irq_out
);

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   bsie_pkg::bsie_apb_req_t req;
   logic        wr_acc;
   logic        rd_acc;
   logic        hit;
   logic [31:0] rd_d;
   logic [31:0] prdata_q;

   assign req.psel    = psel_in;
   assign req.penable = penable_in;
   assign req.pwrite  = pwrite_in;
   assign req.paddr   = paddr_in;
   assign req.pwdata  = pwdata_in;

   assign hit = (req.paddr == bsie_pkg::BSIE_OFS_BRIDGE_EN) ||
                (req.paddr == bsie_pkg::BSIE_OFS_SUPPLY_EN) ||
                (req.paddr == bsie_pkg::BSIE_OFS_BRIDGE_ST) ||
                (req.paddr == bsie_pkg::BSIE_OFS_SUPPLY_ST);
   assign wr_acc = req.psel & req.penable & req.pwrite;
   assign rd_acc = req.psel & req.penable & ~req.pwrite;

   // Zero wait states; unmapped addresses answer with an error
   assign pready_out  = 1'b1;
   assign pslverr_out = req.psel & req.penable & ~hit;

   // ------------------------------------------------------------
   // Enable registers
   // ------------------------------------------------------------
   logic [31:0] bridge_en_q;
   logic [31:0] supply_en_q;

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         bridge_en_q <= bsie_pkg::BSIE_BRIDGE_RESET;
      end else if (wr_acc && req.paddr == bsie_pkg::BSIE_OFS_BRIDGE_EN) begin
         bridge_en_q <= req.pwdata & bsie_pkg::BSIE_BRIDGE_MASK;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         supply_en_q <= bsie_pkg::BSIE_SUPPLY_RESET;
      end else if (wr_acc && req.paddr == bsie_pkg::BSIE_OFS_SUPPLY_EN) begin
         supply_en_q <= req.pwdata & bsie_pkg::BSIE_SUPPLY_MASK;
      end
   end

   // ------------------------------------------------------------
   // Sticky status, cleared on read; a new event wins over the clear
   // ------------------------------------------------------------
   logic [7:0]  supply_rise;
   logic [31:0] bridge_st_q;
   logic [31:0] bridge_st_d;
   logic [7:0]  supply_st_q;
   logic [7:0]  supply_st_d;
   logic        rd_bridge_st;
   logic        rd_supply_st;

   bsie_edge u_edge (
      .clk_in   (clk_in),
      .nrst_in  (nrst_in),
      .level_in (supply_level_in),
      .rise_out (supply_rise)
   );

   assign rd_bridge_st = rd_acc && (req.paddr == bsie_pkg::BSIE_OFS_BRIDGE_ST);
   assign rd_supply_st = rd_acc && (req.paddr == bsie_pkg::BSIE_OFS_SUPPLY_ST);

   // Status records events regardless of enables, so enable writes leave it intact
   // A read clears only what its setup cycle captured, so a later event is not lost
   always_comb begin
      bridge_st_d = rd_bridge_st ? (bridge_st_q & ~prdata_q) : bridge_st_q;
      bridge_st_d = bridge_st_d | (bridge_event_in & bsie_pkg::BSIE_BRIDGE_MASK);
      supply_st_d = rd_supply_st ? (supply_st_q & ~prdata_q[7:0]) : supply_st_q;
      supply_st_d = supply_st_d | supply_rise;
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         bridge_st_q <= 32'h0000_0000;
      end else begin
         bridge_st_q <= bridge_st_d;
      end
   end

   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         supply_st_q <= 8'h00;
      end else begin
         supply_st_q <= supply_st_d;
      end
   end

   // ------------------------------------------------------------
   // Request gating
   // ------------------------------------------------------------
   bsie_pkg::bsie_irq_vec_t gated;

   assign gated.bridge = bridge_st_q & bridge_en_q;
   assign gated.supply = {24'h00_0000, supply_st_q & supply_en_q[7:0]};

   assign bridge_req_out = gated.bridge;
   assign supply_req_out = gated.supply[7:0];
   assign irq_out        = (|gated.bridge) | (|gated.supply);

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (req.paddr)
         bsie_pkg::BSIE_OFS_BRIDGE_EN: begin
            rd_d = bridge_en_q;
         end
         bsie_pkg::BSIE_OFS_SUPPLY_EN: begin
            rd_d = supply_en_q;
         end
         bsie_pkg::BSIE_OFS_BRIDGE_ST: begin
            rd_d = bridge_st_q;
         end
         bsie_pkg::BSIE_OFS_SUPPLY_ST: begin
            rd_d = {24'h00_0000, supply_st_q};
         end
         default: begin
            rd_d = 32'h0000_0000;
         end
      endcase
   end

   // Registered in setup so data stands through the access phase
   always_ff @(posedge clk_in) begin
      if (!nrst_in) begin
         prdata_q <= 32'h0000_0000;
      end else if (req.psel && !req.penable && !req.pwrite) begin
         prdata_q <= rd_d;
      end
   end

   assign prdata_out = prdata_q;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_drv_high;
      @(posedge clk_in) disable iff (!nrst_in)
      bridge_req_out[bsie_pkg::BSIE_DRV_SUPPLY_HIGH] |->
         bridge_en_q[bsie_pkg::BSIE_DRV_SUPPLY_HIGH];
   endproperty
   a_drv_high: assert property (p_drv_high) else $error("drive high leaks");

   property p_drv_low;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_DRV_SUPPLY_LOW] && bridge_en_q[19] && !wr_acc)
         |=> bridge_req_out[19];
   endproperty
   a_drv_low: assert property (p_drv_low) else $error("drive low missed");

   property p_pump;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_req_out[18:16] & ~bridge_en_q[18:16]) == 3'h0;
   endproperty
   a_pump: assert property (p_pump) else $error("pump leaks");

   property p_reserved;
      @(posedge clk_in) disable iff (!nrst_in)
      ((bridge_en_q & ~bsie_pkg::BSIE_BRIDGE_MASK) == 32'h0000_0000) &&
      (supply_en_q[31:8] == 24'h00_0000);
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved set");

   property p_supply_gate;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_req_out & ~supply_en_q[7:0]) == 8'h00;
   endproperty
   a_supply_gate: assert property (p_supply_gate) else $error("supply leaks");

   property p_edge;
      @(posedge clk_in) disable iff (!nrst_in)
      ($past(supply_level_in[0]) && supply_level_in[0] && rd_supply_st && prdata_q[0])
         |=> !supply_st_q[0];
   endproperty
   a_edge: assert property (p_edge) else $error("level retriggered");

   property p_batt_rise;
      @(posedge clk_in) disable iff (!nrst_in)
      $rose(supply_level_in[bsie_pkg::BSIE_BATT_UNDER]) |=> supply_st_q[0];
   endproperty
   a_batt_rise: assert property (p_batt_rise) else $error("edge lost");

   property p_status_kept;
      @(posedge clk_in) disable iff (!nrst_in)
      (wr_acc && bridge_st_q[13]) |=> bridge_st_q[13];
   endproperty
   a_status_kept: assert property (p_status_kept) else $error("status lost");

   property p_irq;
      @(posedge clk_in) disable iff (!nrst_in)
      irq_out == ((|bridge_req_out) || (|supply_req_out));
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch");

   // Enabled events must reach their request line one edge later
   property p_pump_high;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_PUMP_HIGH] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_PUMP_HIGH])
         |=> bridge_req_out[bsie_pkg::BSIE_PUMP_HIGH];
   endproperty
   a_pump_high: assert property (p_pump_high) else $error("pump high lost");

   property p_pump_low1;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_PUMP_LOW_FIRST] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_PUMP_LOW_FIRST])
         |=> bridge_req_out[bsie_pkg::BSIE_PUMP_LOW_FIRST];
   endproperty
   a_pump_low1: assert property (p_pump_low1) else $error("pump low1 lost");

   property p_pump_low2;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_PUMP_LOW_SECOND] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_PUMP_LOW_SECOND])
         |=> bridge_req_out[bsie_pkg::BSIE_PUMP_LOW_SECOND];
   endproperty
   a_pump_low2: assert property (p_pump_low2) else $error("pump low2 lost");

   property p_high_b_oc;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_HIGH_B_OC] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_HIGH_B_OC])
         |=> bridge_req_out[bsie_pkg::BSIE_HIGH_B_OC];
   endproperty
   a_high_b_oc: assert property (p_high_b_oc) else $error("high b oc lost");

   property p_low_a_oc;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_LOW_A_OC] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_LOW_A_OC])
         |=> bridge_req_out[bsie_pkg::BSIE_LOW_A_OC];
   endproperty
   a_low_a_oc: assert property (p_low_a_oc) else $error("low a oc lost");

   property p_high_b_short;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_HIGH_B_SHORT] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_HIGH_B_SHORT])
         |=> bridge_req_out[bsie_pkg::BSIE_HIGH_B_SHORT];
   endproperty
   a_high_b_short: assert property (p_high_b_short) else $error("high b short lost");

   property p_low_a_short;
      @(posedge clk_in) disable iff (!nrst_in)
      (bridge_event_in[bsie_pkg::BSIE_LOW_A_SHORT] && !wr_acc &&
         bridge_en_q[bsie_pkg::BSIE_LOW_A_SHORT])
         |=> bridge_req_out[bsie_pkg::BSIE_LOW_A_SHORT];
   endproperty
   a_low_a_short: assert property (p_low_a_short) else $error("low a short lost");

   property p_core_over;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_CORE_OVER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_CORE_OVER])
         |=> supply_req_out[bsie_pkg::BSIE_CORE_OVER];
   endproperty
   a_core_over: assert property (p_core_over) else $error("core over lost");

   property p_five_over;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_FIVE_OVER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_FIVE_OVER])
         |=> supply_req_out[bsie_pkg::BSIE_FIVE_OVER];
   endproperty
   a_five_over: assert property (p_five_over) else $error("five over lost");

   property p_main_over;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_MAIN_OVER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_MAIN_OVER])
         |=> supply_req_out[bsie_pkg::BSIE_MAIN_OVER];
   endproperty
   a_main_over: assert property (p_main_over) else $error("main over lost");

   property p_batt_over;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_BATT_OVER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_BATT_OVER])
         |=> supply_req_out[bsie_pkg::BSIE_BATT_OVER];
   endproperty
   a_batt_over: assert property (p_batt_over) else $error("battery over lost");

   property p_core_under;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_CORE_UNDER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_CORE_UNDER])
         |=> supply_req_out[bsie_pkg::BSIE_CORE_UNDER];
   endproperty
   a_core_under: assert property (p_core_under) else $error("core under lost");

   property p_five_under;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_FIVE_UNDER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_FIVE_UNDER])
         |=> supply_req_out[bsie_pkg::BSIE_FIVE_UNDER];
   endproperty
   a_five_under: assert property (p_five_under) else $error("five under lost");

   property p_main_under;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_MAIN_UNDER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_MAIN_UNDER])
         |=> supply_req_out[bsie_pkg::BSIE_MAIN_UNDER];
   endproperty
   a_main_under: assert property (p_main_under) else $error("main under lost");

   property p_batt_under;
      @(posedge clk_in) disable iff (!nrst_in)
      (supply_rise[bsie_pkg::BSIE_BATT_UNDER] && !wr_acc &&
         supply_en_q[bsie_pkg::BSIE_BATT_UNDER])
         |=> supply_req_out[bsie_pkg::BSIE_BATT_UNDER];
   endproperty
   a_batt_under: assert property (p_batt_under) else $error("battery under lost");

   c_bridge_irq: cover property (@(posedge clk_in) $rose(bridge_req_out[0]));
   c_supply_irq: cover property (@(posedge clk_in) $rose(supply_req_out[7]));
   c_clear: cover property (@(posedge clk_in) rd_supply_st && |supply_st_q);
endmodule

//--- bsie_mon_model.sv
// Behavioural model of the analog measurement interface feeding the monitor events
module bsie_mon_model (
   input  wire logic        clk_in,
   input  wire logic [31:0] bridge_cmd_in,
   input  wire logic [7:0]  supply_cmd_in,
   output logic      [31:0] bridge_event_out,
   output logic      [7:0]  supply_level_out
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // Event and level outputs
   // ------------------------------------------------------------
   // Outputs start low so the block sees no event at time zero
   initial begin
      bridge_event_out = 32'h0000_0000;
      supply_level_out = 8'h00;
   end

   // One cycle of latency, like a registered comparator stage
   always @(posedge clk_in) begin
      bridge_event_out <= bridge_cmd_in;
      supply_level_out <= supply_cmd_in;
   end
endmodule

//--- bsie_top_bench.sv
// Self-checking bench for the bridge and supply interrupt enables
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin errors++; \
   $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module bsie_top_bench;
   timeunit 1ns;
   timeprecision 100ps;

   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic                   clk_in = 1'b0;
   logic                   nrst_in = 1'b0;
   bsie_pkg::bsie_apb_req_t apb_q = '0;
   logic [31:0]            prdata_out, bridge_event, bridge_req_out, bridge_cmd = 32'h0;
   logic [7:0]             supply_level, supply_req_out, supply_cmd = 8'h00;
   logic                   pready_out, pslverr_out, irq_out;
   logic [31:0]            rd;
   logic                   err;
   int                     errors = 0;
   int                     check_count = 0;
   int                     bit_tab [13] = '{20, 19, 18, 17, 16, 13, 12, 11, 10, 3, 2, 1, 0};

   always #12.5 clk_in = ~clk_in;

   bsie_mon_model mon (.clk_in(clk_in), .bridge_cmd_in(bridge_cmd), .supply_cmd_in(supply_cmd),
      .bridge_event_out(bridge_event), .supply_level_out(supply_level));

   bsie_top dut (.clk_in(clk_in), .nrst_in(nrst_in), .psel_in(apb_q.psel),
      .penable_in(apb_q.penable), .pwrite_in(apb_q.pwrite), .paddr_in(apb_q.paddr),
      .pwdata_in(apb_q.pwdata), .prdata_out(prdata_out), .pready_out(pready_out),
      .pslverr_out(pslverr_out), .bridge_event_in(bridge_event),
      .supply_level_in(supply_level), .bridge_req_out(bridge_req_out),
      .supply_req_out(supply_req_out), .irq_out(irq_out));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // Starts on a fresh edge so release and next setup never share a time step
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      int n;
      @(posedge clk_in);
      apb_q <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
      @(posedge clk_in);
      apb_q.penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 20);
      if (n >= 20) begin
         errors++;
         tally_and_finish();
      end
      rd = prdata_out;
      err = pslverr_out;
      apb_q <= '0;
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic regs_and_reserved();
      apb(1'b0, 8'h5C, 32'h0);
      `CHK("bridge reset", 32'h0000_0000, rd)
      apb(1'b0, 8'h60, 32'h0);
      `CHK("supply reset", 32'h0000_0000, rd)
      apb(1'b1, 8'h5C, 32'hFFFF_FFFF);
      apb(1'b1, 8'h60, 32'hFFFF_FFFF);
      apb(1'b0, 8'h5C, 32'h0);
      `CHK("bridge fields", 32'h001F_3C0F, rd)
      apb(1'b0, 8'h60, 32'h0);
      `CHK("supply fields", 32'h0000_00FF, rd)
      apb(1'b1, 8'h70, 32'h0000_0000);
      `CHK("unmapped write error", 1'b1, err)
      apb(1'b0, 8'h70, 32'h0);
      `CHK("unmapped read", 32'h0000_0000, rd)
      apb(1'b0, 8'h5C, 32'h0);
      `CHK("bridge after stray write", 32'h001F_3C0F, rd)
      apb(1'b1, 8'h5C, 32'h0);
      apb(1'b1, 8'h60, 32'h0);
      $display("test regs_and_reserved done");
   endtask

   // All events fire at once; only the single enabled one may request
   task automatic bridge_gating();
      logic [31:0] m;
      foreach (bit_tab[i]) begin
         m = 32'h1 << bit_tab[i];
         apb(1'b1, 8'h5C, m);
         bridge_cmd <= 32'hFFFF_FFFF;
         @(posedge clk_in);
         bridge_cmd <= 32'h0;
         settle(3);
         `CHK("bridge request", m, bridge_req_out)
         `CHK("irq enabled", 1'b1, irq_out)
         apb(1'b1, 8'h5C, 32'h0);
         #1;
         `CHK("bridge masked", 32'h0, bridge_req_out)
         apb(1'b0, 8'h64, 32'h0);
         `CHK("bridge status kept", 32'h001F_3C0F, rd)
      end
      $display("test bridge_gating done");
   endtask

   // Held levels must request once only, on their rising edge
   task automatic supply_edges();
      apb(1'b1, 8'h60, 32'h0000_00FF);
      for (int b = 0; b < 8; b++) begin
         supply_cmd <= 8'h01 << b;
         settle(4);
         `CHK("supply req", 8'h01 << b, supply_req_out)
         apb(1'b0, 8'h68, 32'h0);
         `CHK("supply status", 32'h1 << b, rd)
         settle(3);
         `CHK("held level quiet", 8'h00, supply_req_out)
         supply_cmd <= 8'h00;
         settle(3);
      end
      apb(1'b1, 8'h60, 32'h0);
      supply_cmd <= 8'hFF;
      settle(4);
      `CHK("supply all masked", 8'h00, supply_req_out)
      `CHK("irq masked", 1'b0, irq_out)
      apb(1'b0, 8'h68, 32'h0);
      `CHK("supply status masked", 32'h0000_00FF, rd)
      supply_cmd <= 8'h00;
      $display("test supply_edges done");
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk_in);
      nrst_in <= 1'b1;
      regs_and_reserved();
      bridge_gating();
      supply_edges();
      tally_and_finish();
   end
endmodule
